/* rtl/oar_readout.sv */
// Readout and channel sleep logic of an eight-channel converter with a serial link.
// Assumes results arrive as 8 words of 24 bits, serial_clock and frame_strobe are
// synchronous to clk and slower than half its rate, and chain_in changes with serial_clock.
`timescale 1ns/1ps
`include "oar_defs.svh"
module oar_readout (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [7:0] channel_sleep_n,
   input wire oar_pkg::oar_mode_t mode_select,
   input wire logic clock_divide_select,
   input wire oar_pkg::oar_layout_t layout_select,
   input wire logic serial_clock,
   input wire logic frame_strobe,
   input wire logic chain_in,
   input wire logic [191:0] sample_data,
   input wire logic sample_valid,
   output logic sample_ready,
   output logic conversion_tick,
   output logic result_ready_n,
   output logic [7:0] data_out,
   output logic bias_off,
   output logic link_active
);
   import oar_pkg::*;

   // Master clock cycles in one result period.
   function automatic logic [11:0] conv_period(input oar_mode_t m, input logic div);
      logic [11:0] p;
      p = `OAR_CLKS_HS;
      case (m)
         OAR_MODE_HS: p = `OAR_CLKS_HS;
         OAR_MODE_HR: p = `OAR_CLKS_HR;
         OAR_MODE_LP: p = div ? `OAR_CLKS_LP_DIV1 : `OAR_CLKS_LP_DIV0;
         OAR_MODE_LS: p = div ? `OAR_CLKS_LS_DIV1 : `OAR_CLKS_LS_DIV0;
         default: p = `OAR_CLKS_HS;
      endcase
      return p;
   endfunction : conv_period

   // True for the three frame-strobe layouts.
   function automatic logic is_frame(input oar_layout_t l);
      return (l == OAR_FS_DYN) || (l == OAR_FS_FIX) || (l == OAR_FS_DISC);
   endfunction : is_frame

   // True for the two discrete-pin layouts.
   function automatic logic is_discrete(input oar_layout_t l);
      return (l == OAR_SPI_DISC) || (l == OAR_FS_DISC);
   endfunction : is_discrete

   // True for the two packed multiplexed layouts.
   function automatic logic is_dynamic(input oar_layout_t l);
      return (l == OAR_SPI_DYN) || (l == OAR_FS_DYN);
   endfunction : is_dynamic

   // True for layouts that run the serial link; modulator and reserved codes do not.
   function automatic logic is_link(input oar_layout_t l);
      logic ok;
      ok = 1'b0;
      case (l)
         OAR_SPI_DYN, OAR_SPI_FIX, OAR_SPI_DISC: ok = 1'b1;
         OAR_FS_DYN, OAR_FS_FIX, OAR_FS_DISC: ok = 1'b1;
         OAR_MODULATOR: ok = 1'b0;
         default: ok = 1'b0;
      endcase
      return ok;
   endfunction : is_link

   // Builds the multiplexed frame with channel 1 at the top of the used length.
   function automatic logic [191:0] pack_frame(input logic [191:0] w, input logic [7:0] m,
                                               input logic dyn);
      logic [191:0] acc;
      acc = '0;
      for (int i = 0; i < `OAR_CHANNELS; i++) begin
         if (m[i]) begin
            acc = {acc[167:0], w[`OAR_WORD_BITS*i +: `OAR_WORD_BITS]};
         end else if (!dyn) begin
            acc = {acc[167:0], 24'h000000};
         end
      end
      return acc;
   endfunction : pack_frame

   // Number of frame bits the device itself sends before the chain data.
   function automatic logic [7:0] frame_len(input logic [7:0] m, input logic dyn);
      logic [7:0] n;
      n = 8'h00;
      for (int i = 0; i < `OAR_CHANNELS; i++) begin
         if (m[i] || !dyn) begin
            n = n + `OAR_WORD_LEN;
         end
      end
      return n;
   endfunction : frame_len

   logic [11:0] period;
   logic [11:0] conv_cnt;
   logic conv_tick;
   logic pre_tick;
   logic [7:0] asleep;
   logic [7:0] ch_ready;
   logic all_asleep;
   logic link_en;
   logic frame_mode;
   logic sclk_q;
   logic fs_q;
   logic sclk_fall;
   logic fs_rise;
   logic load_evt;
   logic take;
   oar_link_t link_state;
   oar_link_t next_link_state;
   logic [191:0] frame_sr;
   logic [7:0] len;
   logic tdm_bit;
   logic [7:0] disc_msb;

   oar_stream_if #(.WIDTH(`OAR_FRAME_BITS)) push_s ();
   oar_stream_if #(.WIDTH(`OAR_FRAME_BITS)) pop_s ();

   // Results from the filter enter the buffer; its ready holds the filter back.
   assign push_s.data = sample_data;
   assign push_s.valid = sample_valid;
   assign sample_ready = push_s.ready;
   assign pop_s.ready = take;

   oar_fifo #(.WIDTH(`OAR_FRAME_BITS), .DEPTH(`OAR_FIFO_DEPTH)) result_buf (
      .clk(clk),
      .sys_rst(sys_rst),
      .in_s(push_s),
      .out_s(pop_s)
   );

   // Result period counter; a shrinking period after a mode change restarts it.
   assign period = conv_period(mode_select, clock_divide_select);
   assign conv_tick = (conv_cnt == period - 12'd1);
   assign pre_tick = (conv_cnt == period - 12'd2);
   always_ff @(posedge clk) begin
      if (sys_rst || conv_cnt >= period - 12'd1) begin
         conv_cnt <= 12'h000;
      end else begin
         conv_cnt <= conv_cnt + 12'd1;
      end
   end

   // Tells the filter that a result period has ended.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         conversion_tick <= 1'b0;
      end else begin
         conversion_tick <= conv_tick;
      end
   end

   // Per-channel sleep detection and wake-up settling; all channels count the same ticks.
   for (genvar g = 0; g < `OAR_CHANNELS; g++) begin : g_chan
      logic [1:0] low_cnt;
      logic [7:0] settle;
      logic [7:0] settle_target;
      assign settle_target = frame_mode ? `OAR_SETTLE_FS : `OAR_SETTLE_SPI;

      // Counts low cycles; the second one puts the channel to sleep.
      always_ff @(posedge clk) begin
         if (sys_rst) begin
            low_cnt <= 2'h0;
            asleep[g] <= 1'b0;
         end else if (channel_sleep_n[g]) begin
            low_cnt <= 2'h0;
            asleep[g] <= 1'b0;
         end else begin
            if (low_cnt != `OAR_SLEEP_MIN_CLKS) begin
               low_cnt <= low_cnt + 2'd1;
            end
            if (low_cnt == `OAR_SLEEP_MIN_CLKS - 2'd1) begin
               asleep[g] <= 1'b1;
            end
         end
      end

      // Counts result periods after wake-up until the channel's data are valid.
      always_ff @(posedge clk) begin
         if (sys_rst || asleep[g]) begin
            settle <= 8'h00;
            ch_ready[g] <= 1'b0;
         end else if (conv_tick && !ch_ready[g]) begin
            if (settle >= settle_target - 8'd1) begin
               ch_ready[g] <= 1'b1;
            end else begin
               settle <= settle + 8'd1;
            end
         end
      end
   end

   // Link enable and the minimal-power flag.
   assign all_asleep = &asleep;
   assign frame_mode = is_frame(layout_select);
   assign link_en = !all_asleep && is_link(layout_select);
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         bias_off <= 1'b0;
         link_active <= 1'b0;
      end else begin
         bias_off <= all_asleep;
         link_active <= link_en;
      end
   end

   // Edge detection on the serial clock and frame strobe pins.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sclk_q <= 1'b0;
         fs_q <= 1'b0;
      end else begin
         sclk_q <= serial_clock;
         fs_q <= frame_strobe;
      end
   end
   assign sclk_fall = sclk_q && !serial_clock;
   assign fs_rise = !fs_q && frame_strobe;

   // A frame starts on the period tick in SPI, on the strobe edge in frame protocol.
   assign load_evt = link_en && (frame_mode ? fs_rise : conv_tick);
   assign take = load_evt && pop_s.valid;

   // Link state: ready is announced only while an SPI result waits to be read.
   always_comb begin
      next_link_state = link_state;
      case (link_state)
         OAR_LINK_OFF: begin
            if (link_en) begin
               next_link_state = OAR_LINK_IDLE;
            end
         end
         OAR_LINK_IDLE: begin
            if (take && !frame_mode) begin
               next_link_state = OAR_LINK_READY;
            end
         end
         OAR_LINK_READY: begin
            if (take && !frame_mode) begin
               next_link_state = OAR_LINK_READY;
            end else if (sclk_fall || pre_tick || frame_mode) begin
               next_link_state = OAR_LINK_IDLE;
            end
         end
         default: next_link_state = OAR_LINK_OFF;
      endcase
      if (!link_en) begin
         next_link_state = OAR_LINK_OFF;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         link_state <= OAR_LINK_OFF;
      end else begin
         link_state <= next_link_state;
      end
   end

   // Ready is low only in the waiting state, so an unread result gives a high pulse.
   assign result_ready_n = (link_state != OAR_LINK_READY);

   // Multiplexed shift register: loads the frame, shifts in chain bits at the bottom.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         frame_sr <= '0;
         len <= 8'h00;
      end else if (!link_en) begin
         frame_sr <= '0;
         len <= 8'h00;
      end else if (load_evt && (take || frame_mode)) begin
         // Frame protocol with nothing buffered sends zeros for the whole frame.
         frame_sr <= take ? pack_frame(pop_s.data, ch_ready, is_dynamic(layout_select))
                          : '0;
         len <= frame_len(ch_ready, is_dynamic(layout_select));
      end else if (sclk_fall) begin
         frame_sr <= {frame_sr[190:0], chain_in};
      end
   end

   // Tap at the top of the used length, so chain bits follow the last own channel.
   assign tdm_bit = (len == 8'h00) ? frame_sr[0] : frame_sr[len - 8'd1];

   // Discrete shifters, one per pin; zeros fill in behind the word.
   for (genvar g = 0; g < `OAR_CHANNELS; g++) begin : g_disc
      logic [23:0] disc_sr;
      always_ff @(posedge clk) begin
         if (sys_rst || !link_en) begin
            disc_sr <= 24'h000000;
         end else if (load_evt && (take || frame_mode)) begin
            disc_sr <= (take && ch_ready[g]) ? pop_s.data[`OAR_WORD_BITS*g +: `OAR_WORD_BITS]
                                             : 24'h000000;
         end else if (sclk_fall) begin
            disc_sr <= {disc_sr[22:0], 1'b0};
         end
      end
      assign disc_msb[g] = disc_sr[23];
   end

   // Registered data pins; only pin one carries the multiplexed stream.
   always_ff @(posedge clk) begin
      if (sys_rst || link_state == OAR_LINK_OFF) begin
         data_out <= `OAR_RST_OUT;
      end else if (is_discrete(layout_select)) begin
         data_out <= disc_msb;
      end else begin
         data_out <= {7'h00, tdm_bit};
      end
   end

endmodule : oar_readout

/* rtl/oar_defs.svh */
// Constants of the octal converter readout: sizes, settling counts and result periods.
// Assumes it is included by its bare name wherever these macros are needed.
`ifndef OAR_DEFS_SVH
`define OAR_DEFS_SVH

// Channel count, bits per channel word and bits in a full frame.
`define OAR_CHANNELS 8
`define OAR_WORD_BITS 24
`define OAR_FRAME_BITS 192
`define OAR_FRAME_LEN_BITS 8'd192
`define OAR_WORD_LEN 8'd24

// Depth of the result buffer in words.
`define OAR_FIFO_DEPTH 8

// Master clock periods a sleep input must stay low before the channel sleeps.
`define OAR_SLEEP_MIN_CLKS 2'd2

// Conversion periods from wake-up until a channel delivers valid data.
`define OAR_SETTLE_SPI 8'd129
`define OAR_SETTLE_FS 8'd128

// Master clock cycles per output result for each mode and clock-divide setting.
`define OAR_CLKS_HS 12'd256
`define OAR_CLKS_HR 12'd512
`define OAR_CLKS_LP_DIV1 12'd512
`define OAR_CLKS_LP_DIV0 12'd256
`define OAR_CLKS_LS_DIV1 12'd2560
`define OAR_CLKS_LS_DIV0 12'd512

// Value of the data pins in reset and while the link is off.
`define OAR_RST_OUT 8'h00

`endif

/* rtl/oar_pkg.sv */
// Types of the octal converter readout: operating modes, output layouts, link states.
// Assumes nothing of its surroundings.
package oar_pkg;

   // Operating mode select.
   typedef enum logic [1:0] {
      OAR_MODE_HS = 2'h0,
      OAR_MODE_HR = 2'h1,
      OAR_MODE_LP = 2'h2,
      OAR_MODE_LS = 2'h3
   } oar_mode_t;

   // Output layout select: protocol and data arrangement.
   typedef enum logic [2:0] {
      OAR_SPI_DYN = 3'h0,
      OAR_SPI_FIX = 3'h1,
      OAR_SPI_DISC = 3'h2,
      OAR_FS_DYN = 3'h3,
      OAR_FS_FIX = 3'h4,
      OAR_FS_DISC = 3'h5,
      OAR_MODULATOR = 3'h6,
      OAR_RESERVED = 3'h7
   } oar_layout_t;

   // State of the serial link.
   typedef enum logic [1:0] {
      OAR_LINK_OFF = 2'h0,
      OAR_LINK_IDLE = 2'h1,
      OAR_LINK_READY = 2'h2
   } oar_link_t;

endpackage : oar_pkg

/* rtl/oar_stream_if.sv */
// Valid and ready word stream between the readout and its result buffer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface oar_stream_if #(parameter int WIDTH = 192);
   logic [WIDTH-1:0] data;
   logic valid;
   logic ready;

   // The producing end drives data and valid.
   modport src (output data, output valid, input ready);
   // The consuming end drives ready.
   modport snk (input data, input valid, output ready);
endinterface : oar_stream_if

/* rtl/oar_fifo.sv */
// Result buffer: a small memory with a registered read stage.
// Assumes DEPTH is a power of two and a single clock for both ends.
`timescale 1ns/1ps
module oar_fifo #(
   parameter int WIDTH = 192,
   parameter int DEPTH = 8
) (
   input wire logic clk,
   input wire logic sys_rst,
   oar_stream_if.snk in_s,
   oar_stream_if.src out_s
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [CW-1:0] count;
   logic push;
   logic load;

   // A word is written when offered and room remains; the read stage refills when free.
   assign in_s.ready = (count != CW'(DEPTH));
   assign push = in_s.valid && in_s.ready;
   assign load = (count != '0) && (!out_s.valid || out_s.ready);

   // Storage array, written only.
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr] <= in_s.data;
      end
   end

   // Pointers wrap naturally because the depth is a power of two.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + AW'(1);
         end
         if (load) begin
            rd_ptr <= rd_ptr + AW'(1);
         end
      end
   end

   // Occupancy of the memory, not counting the read stage.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         count <= '0;
      end else if (push && !load) begin
         count <= count + CW'(1);
      end else if (load && !push) begin
         count <= count - CW'(1);
      end
   end

   // Registered read stage holding the oldest word.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         out_s.valid <= 1'b0;
         out_s.data <= '0;
      end else if (load) begin
         out_s.valid <= 1'b1;
         out_s.data <= mem[rd_ptr];
      end else if (out_s.ready) begin
         out_s.valid <= 1'b0;
      end
   end

endmodule : oar_fifo

/* tb/oar_readout_sva.sv */
// Concurrent checks on the ports of the converter readout.
// Assumes one clock domain and a synchronous active-high reset; bound from the bench.
`timescale 1ns/1ps
module oar_readout_sva (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [7:0] channel_sleep_n,
   input wire oar_pkg::oar_mode_t mode_select,
   input wire logic clock_divide_select,
   input wire oar_pkg::oar_layout_t layout_select,
   input wire logic serial_clock,
   input wire logic conversion_tick,
   input wire logic result_ready_n,
   input wire logic [7:0] data_out,
   input wire logic bias_off,
   input wire logic link_active
);
   import oar_pkg::*;
   logic [11:0] gap;
   logic armed;
   oar_mode_t mode_q;
   logic div_q;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   // Master clocks per result for a mode and divide setting.
   function automatic logic [11:0] period_of(input oar_mode_t m, input logic d);
      case (m)
         OAR_MODE_HS: return 12'd256;
         OAR_MODE_HR: return 12'd512;
         OAR_MODE_LP: return d ? 12'd512 : 12'd256;
         default: return d ? 12'd2560 : 12'd512;
      endcase
   endfunction : period_of

   // Cycles since the last tick; armed only while the mode held still over that span.
   always_ff @(posedge clk) begin
      if (sys_rst || conversion_tick) begin
         gap <= 12'd1;
         armed <= !sys_rst;
         mode_q <= mode_select;
         div_q <= clock_divide_select;
      end else begin
         gap <= gap + 12'd1;
         if (mode_select != mode_q || clock_divide_select != div_q) begin
            armed <= 1'b0;
         end
      end
   end

   tick_pulse_a: assert property (conversion_tick |=> !conversion_tick [*8])
      else $error("conversion tick too long");
   tick_period_a: assert property (conversion_tick && armed && mode_select == mode_q
      && clock_divide_select == div_q |-> gap == period_of(mode_select, clock_divide_select))
      else $error("result period wrong");
   bias_set_a: assert property ((channel_sleep_n == 8'h00) [*4] |=> bias_off)
      else $error("bias not off with all asleep");
   bias_clear_a: assert property (channel_sleep_n != 8'h00 |-> ##2 !bias_off)
      else $error("bias off with a channel awake");
   link_layout_a: assert property ((layout_select inside {OAR_MODULATOR, OAR_RESERVED}) [*2]
      |-> !link_active)
      else $error("link on for a non-serial layout");
   idle_quiet_a: assert property (!link_active [*3] |-> data_out == 8'h00 && result_ready_n)
      else $error("outputs active with link off");
   ready_fall_a: assert property ($fell(result_ready_n) |-> conversion_tick
      && layout_select inside {OAR_SPI_DYN, OAR_SPI_FIX, OAR_SPI_DISC})
      else $error("ready fell off a tick");
   frame_ready_a: assert property ((layout_select inside {OAR_FS_DYN, OAR_FS_FIX,
      OAR_FS_DISC}) [*3] |-> result_ready_n)
      else $error("ready low in frame protocol");
   ready_release_a: assert property (!result_ready_n && $fell(serial_clock)
      |-> ##[1:3] result_ready_n)
      else $error("ready not released by serial fall");
endmodule : oar_readout_sva

/* tb/oar_host_model.sv */
// Host reader of the serial link: waits for ready or starts a frame, then clocks bits in.
// Assumes the bench raises go with fs, nbits and chain_bit set, and holds go until done.
`timescale 1ns/1ps
module oar_host_model (
   input wire logic clk,
   input wire logic go,
   input wire logic fs,
   input wire logic [8:0] nbits,
   input wire logic chain_bit,
   input wire logic result_ready_n,
   input wire logic [7:0] data_out,
   output logic serial_clock,
   output logic frame_strobe,
   output logic chain_in,
   output logic done,
   output logic [7:0] cap [256]
);
   logic run;
   logic [10:0] cnt;

   // Link lines idle low from time zero.
   initial begin
      serial_clock = 1'b0;
      frame_strobe = 1'b0;
      chain_in = 1'b0;
      done = 1'b0;
      run = 1'b0;
      cnt = 11'h000;
   end

   // Serial clock at a quarter of the master clock, stopped between reads; a bit is
   // taken just before each fall, so it has stood two master clocks.
   always @(posedge clk) begin
      if (!go) begin
         done <= 1'b0;
         run <= 1'b0;
         frame_strobe <= 1'b0;
         serial_clock <= 1'b0;
      end else if (!run && !done) begin
         if (fs || !result_ready_n) begin
            run <= 1'b1;
            cnt <= 11'h000;
            frame_strobe <= fs;
            chain_in <= chain_bit;
         end
      end else if (run) begin
         cnt <= cnt + 11'h001;
         if (cnt[1:0] == 2'h1) begin
            serial_clock <= 1'b1;
         end
         if (cnt[1:0] == 2'h3) begin
            cap[cnt[10:2]] <= data_out;
            serial_clock <= 1'b0;
            if (cnt[10:2] == nbits - 9'h001) begin
               run <= 1'b0;
               done <= 1'b1;
            end
         end
      end
   end
endmodule : oar_host_model

/* tb/tb.sv */
// Bench of the converter readout: reset, sleep, layouts, periods, buffer and serial reads.
// Assumes the checker and host model files are compiled before this one.
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin num_errors++; \
$display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module tb;
   import oar_pkg::*;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [7:0] channel_sleep_n = 8'hff;
   oar_mode_t mode_select = OAR_MODE_HS;
   logic clock_divide_select = 1'b1;
   oar_layout_t layout_select = OAR_SPI_FIX;
   logic [191:0] sample_data = '0;
   logic sample_valid = 1'b0;
   logic go = 1'b0;
   logic fs = 1'b0;
   logic chain_bit = 1'b0;
   logic [8:0] nbits = 9'h000;
   logic serial_clock, frame_strobe, chain_in, sample_ready, conversion_tick;
   logic result_ready_n, bias_off, link_active, done;
   logic [7:0] data_out;
   logic [7:0] cap [256];
   logic [31:0] seed = 32'h6b07ae3c;
   logic [191:0] w;
   logic [255:0] s;
   int num_errors = 0;
   int compares = 0;
   int cycles = 0;
   int acc;
   int pm [6] = '{0, 1, 2, 2, 3, 3};
   bit pd [6] = '{1, 1, 1, 0, 1, 0};
   int pp [6] = '{256, 512, 512, 256, 2560, 512};

   // Master clock, 50 ns period, below the fastest rate the SPI link allows.
   always #25 clk = ~clk;

   oar_readout dut_u (.clk(clk), .sys_rst(sys_rst), .channel_sleep_n(channel_sleep_n),
      .mode_select(mode_select), .clock_divide_select(clock_divide_select),
      .layout_select(layout_select), .serial_clock(serial_clock),
      .frame_strobe(frame_strobe), .chain_in(chain_in), .sample_data(sample_data),
      .sample_valid(sample_valid), .sample_ready(sample_ready),
      .conversion_tick(conversion_tick), .result_ready_n(result_ready_n),
      .data_out(data_out), .bias_off(bias_off), .link_active(link_active));
   oar_host_model host_u (.clk(clk), .go(go), .fs(fs), .nbits(nbits), .chain_bit(chain_bit),
      .result_ready_n(result_ready_n), .data_out(data_out), .serial_clock(serial_clock),
      .frame_strobe(frame_strobe), .chain_in(chain_in), .done(done), .cap(cap));

   // Next value of the shift-register random source.
   function automatic logic [31:0] lfsr(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction : lfsr

   // Expected bits on the first pin for a word, awake mask, layout and chain bit.
   function automatic logic [255:0] tdm_stream(input logic [191:0] x, input logic [7:0] on,
         input logic fix, input logic c);
      int k;
      logic [255:0] r;
      k = 0;
      r = {256{c}};
      for (int g = 0; g < 8; g++) begin
         if (on[g] || fix) begin
            for (int b = 23; b >= 0; b--) begin
               r[k] = on[g] & x[24 * g + b];
               k++;
            end
         end
      end
      return r;
   endfunction : tdm_stream

   // Fresh random result word.
   task automatic new_word();
      for (int i = 0; i < 6; i++) begin
         seed = lfsr(seed);
         w[32 * i +: 32] = seed;
      end
   endtask : new_word

   // Waits for n conversion ticks.
   task automatic wait_tick(input int n);
      repeat (n) begin
         @(posedge clk);
         while (conversion_tick !== 1'b1) @(posedge clk);
      end
   endtask : wait_tick

   // Hands one word to the buffer, then lets the host read n bits of the next result.
   task automatic read(input int n, input logic f);
      new_word();
      seed = lfsr(seed);
      sample_data <= w;
      sample_valid <= 1'b1;
      @(posedge clk);
      while (sample_ready !== 1'b1) @(posedge clk);
      sample_valid <= 1'b0;
      repeat (3) @(posedge clk);
      chain_bit <= seed[0];
      fs <= f;
      nbits <= 9'(n);
      go <= 1'b1;
      @(posedge clk);
      while (done !== 1'b1) @(posedge clk);
      go <= 1'b0;
      @(posedge clk);
   endtask : read

   // Compares the first n bits taken from the first pin.
   task automatic check_tdm(input int n, input logic [7:0] on, input logic fix);
      s = tdm_stream(w, on, fix, chain_bit);
      for (int i = 0; i < n; i++) begin
         `CHK(cap[i][0], s[i])
         `CHK(cap[i][7:1], 7'h00)
      end
   endtask : check_tdm

   // Compares n bits of every pin: 24 bits of an awake channel, zeros after.
   task automatic check_disc(input int n, input logic [7:0] on);
      for (int i = 0; i < n; i++) begin
         for (int g = 0; g < 8; g++) begin
            `CHK(cap[i][g], (i < 24 && on[g]) ? w[24 * g + 23 - i] : 1'b0)
         end
      end
   endtask : check_disc

   // Prints the counts and the verdict, then ends the run.
   task automatic stop_test();
      $display("mismatches %0d comparisons %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : stop_test

   // Cuts a hung run short.
   always @(posedge clk) begin
      cycles++;
      if (cycles == 95000) begin
         num_errors++;
         stop_test();
      end
   end

   // Main sequence.
   initial begin
      repeat (20) @(posedge clk);
      `CHK({result_ready_n, data_out, bias_off}, 10'h200)
      `CHK({link_active, conversion_tick, sample_ready}, 3'h1)
      sys_rst <= 1'b0;
      @(posedge clk);
      acc = 0;
      new_word();
      sample_data <= w;
      sample_valid <= 1'b1;
      repeat (12) begin
         @(posedge clk);
         if (sample_ready === 1'b1) begin
            acc++;
            new_word();
            sample_data <= w;
         end
      end
      sample_valid <= 1'b0;
      `CHK(acc, 9)
      `CHK(sample_ready, 1'b0)
      channel_sleep_n <= 8'h00;
      @(posedge clk);
      channel_sleep_n <= 8'hff;
      repeat (4) @(posedge clk);
      `CHK(bias_off, 1'b0)
      channel_sleep_n <= 8'h00;
      repeat (5) @(posedge clk);
      `CHK({bias_off, link_active, data_out, result_ready_n}, 11'h401)
      channel_sleep_n <= 8'hff;
      for (int l = 0; l < 8; l++) begin
         layout_select <= oar_layout_t'(l);
         repeat (3) @(posedge clk);
         `CHK(link_active, l < 6)
      end
      layout_select <= OAR_SPI_FIX;
      for (int m = 0; m < 6; m++) begin
         wait_tick(1);
         mode_select <= oar_mode_t'(pm[m]);
         clock_divide_select <= pd[m];
         wait_tick(1);
         acc = 0;
         do begin
            @(posedge clk);
            acc++;
         end while (conversion_tick !== 1'b1);
         `CHK(acc, pp[m])
      end
      mode_select <= OAR_MODE_HS;
      clock_divide_select <= 1'b1;
      wait_tick(135);
      channel_sleep_n <= 8'hfb;
      layout_select <= OAR_SPI_DISC;
      wait_tick(2);
      read(28, 1'b0);
      check_disc(28, 8'hfb);
      channel_sleep_n <= 8'h0a;
      layout_select <= OAR_SPI_DYN;
      wait_tick(2);
      read(52, 1'b0);
      check_tdm(52, 8'h0a, 1'b0);
      layout_select <= OAR_SPI_FIX;
      wait_tick(2);
      read(48, 1'b0);
      check_tdm(48, 8'h0a, 1'b1);
      layout_select <= OAR_FS_DISC;
      wait_tick(2);
      read(24, 1'b1);
      check_disc(24, 8'h0a);
      layout_select <= OAR_SPI_DYN;
      channel_sleep_n <= 8'h0b;
      wait_tick(124);
      read(52, 1'b0);
      check_tdm(52, 8'h0a, 1'b0);
      wait_tick(8);
      read(52, 1'b0);
      check_tdm(52, 8'h0b, 1'b0);
      stop_test();
   end
endmodule : tb

bind oar_readout oar_readout_sva chk_u (.clk(clk), .sys_rst(sys_rst),
   .channel_sleep_n(channel_sleep_n), .mode_select(mode_select),
   .clock_divide_select(clock_divide_select), .layout_select(layout_select),
   .serial_clock(serial_clock), .conversion_tick(conversion_tick),
   .result_ready_n(result_ready_n), .data_out(data_out), .bias_off(bias_off),
   .link_active(link_active));
